// File: verilog/qafc_cfg.svh
// constants for the queued converter command and result front end
`ifndef QAFC_CFG_SVH
`define QAFC_CFG_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define QAFC_NQ 6
`define QAFC_DEPTH 3'h4
`define QAFC_SB_DEPTH 2'h2
// ----------------------------------------
// command word field positions
// ----------------------------------------
`define QAFC_F_EOQ 31
`define QAFC_F_RQ_HI 30
`define QAFC_F_RQ_LO 28
`define QAFC_F_SMP_HI 27
`define QAFC_F_SMP_LO 26
`define QAFC_F_TS 25
`define QAFC_F_SGN 24
`define QAFC_F_REF_HI 23
`define QAFC_F_REF_LO 22
`define QAFC_F_CH_HI 21
`define QAFC_F_CH_LO 15
// ----------------------------------------
// timing, channels, calibration
// ----------------------------------------
`define QAFC_SMP0 8'h02
`define QAFC_SMP1 8'h08
`define QAFC_SMP2 8'h40
`define QAFC_SMP3 8'h80
`define QAFC_INT_CH 7'h28
`define QAFC_EXT_BASE 6'h21
`define QAFC_GAIN_SH 14
`define QAFC_MID 13'h0800
`define QAFC_CODE_MAX 17'h00FFF
`endif

// File: verilog/qafc_pkg.sv
// types shared by the queued converter front end
package qafc_pkg;
  // trigger mode of one command queue
  typedef enum logic [2:0] {
    QAFC_TRG_OFF = 3'h0,
    QAFC_TRG_SW = 3'h1,
    QAFC_TRG_RISE = 3'h2,
    QAFC_TRG_FALL = 3'h3,
    QAFC_TRG_HIGH = 3'h4,
    QAFC_TRG_LOW = 3'h5
  } qafc_trig_e;
  // converter sequence, gray along the path
  typedef enum logic [1:0] {
    QAFC_IDLE = 2'h0,
    QAFC_SAMP = 2'h1,
    QAFC_CONV = 2'h3,
    QAFC_STORE = 2'h2
  } qafc_state_e;
  // host push of one command word
  typedef struct packed {
    logic valid;
    logic [2:0] qid;
    logic [31:0] data;
  } qafc_push_s;
  // converter control bundle
  typedef struct packed {
    logic start;
    logic sample;
    logic [5:0] chan;
    logic [1:0] ref_sel;
    logic ext_en;
    logic [2:0] ext_sel;
  } qafc_adc_s;
endpackage

// File: verilog/qafc_top.sv
// queued converter command and result queue front end
`timescale 1ns/100ps
`include "qafc_cfg.svh"
module qafc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire qafc_pkg::qafc_push_s cmd_push,
  output logic [5:0] cmd_push_ready,
  input wire logic res_pop_req,
  input wire logic [2:0] res_pop_qid,
  output logic res_pop_valid,
  output logic [31:0] res_pop_data,
  input wire qafc_pkg::qafc_trig_e trig_mode [6],
  input wire logic [5:0] sw_trig,
  input wire logic [5:0] hw_trig_pin,
  input wire logic [3:0] trig_filt_len,
  output logic [5:0] cmd_fill_req,
  output logic [5:0] res_drain_req,
  output logic [5:0] coh_irq,
  output qafc_pkg::qafc_adc_s adc_ctl,
  input wire logic adc_done,
  input wire logic [11:0] adc_raw,
  input wire logic [15:0] cal_gain,
  input wire logic [13:0] cal_offset
);
  import qafc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sample length selected by a command
  function automatic logic [7:0] smp_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: smp_len = `QAFC_SMP0;
      2'h1: smp_len = `QAFC_SMP1;
      2'h2: smp_len = `QAFC_SMP2;
      2'h3: smp_len = `QAFC_SMP3;
    endcase
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [31:0] cq_mem [6][4]; // command queues
  logic [1:0] cq_wp_q [6];
  logic [1:0] cq_rp_q [6];
  logic [2:0] cq_cnt_q [6];
  logic [31:0] rq_mem [6][4]; // result queues
  logic [1:0] rq_wp_q [6];
  logic [1:0] rq_rp_q [6];
  logic [2:0] rq_cnt_q [6];
  logic [31:0] sb_mem [2]; // staging buffer
  logic sb_wp_q, sb_rp_q;
  logic [1:0] sb_cnt_q;
  // trigger path
  logic [5:0] ts1_q, ts2_q, ts3_q, tstb_q, tflt_q, tflt_d1_q, armed_q;
  logic [3:0] tcnt_q [6];
  logic [5:0] trig_act, elig;
  // arbitration
  logic grant_v;
  logic [2:0] grant;
  logic [2:0] last_q_q; // queue of last forwarded word
  logic mid_q; // last word was not end of batch
  // converter sequence
  qafc_state_e st_q;
  logic [31:0] cur_q; // command under execution
  logic [7:0] scnt_q;
  logic [15:0] ts_q; // free running time base
  logic [15:0] stamp_q;
  logic [15:0] res_val_q;
  logic sb_pop, rq_push;
  logic [2:0] rq_qid;

  // ----------------------------------------
  // trigger synchronise, filter, detect
  // ----------------------------------------
  // pins pass three flops; a change counts when second and third agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ts1_q <= 6'h00;
      ts2_q <= 6'h00;
      ts3_q <= 6'h00;
      tstb_q <= 6'h00;
    end else begin
      ts1_q <= hw_trig_pin;
      ts2_q <= ts1_q;
      ts3_q <= ts2_q;
      tstb_q <= (ts2_q & ts3_q) | (tstb_q & (ts2_q | ts3_q));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tflt_q <= 6'h00;
      tflt_d1_q <= 6'h00;
      for (int i = 0; i < `QAFC_NQ; i++) tcnt_q[i] <= 4'h0;
    end else begin
      tflt_d1_q <= tflt_q;
      for (int i = 0; i < `QAFC_NQ; i++) begin
        if (tstb_q[i] == tflt_q[i]) begin
          tcnt_q[i] <= 4'h0;
        end else if (tcnt_q[i] >= trig_filt_len) begin
          // level held long enough: accept it
          tflt_q[i] <= tstb_q[i];
          tcnt_q[i] <= 4'h0;
        end else begin
          tcnt_q[i] <= tcnt_q[i] + 4'h1;
        end
      end
    end
  end

  // arm from software or filtered edges; set beats clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_q <= 6'h00;
    end else begin
      for (int i = 0; i < `QAFC_NQ; i++) begin
        if (grant_v && grant == 3'(i) && cq_mem[i][cq_rp_q[i]][`QAFC_F_EOQ])
          armed_q[i] <= 1'b0;
        if ((trig_mode[i] == QAFC_TRG_SW && sw_trig[i]) ||
            (trig_mode[i] == QAFC_TRG_RISE && tflt_q[i] && !tflt_d1_q[i]) ||
            (trig_mode[i] == QAFC_TRG_FALL && !tflt_q[i] && tflt_d1_q[i]))
          armed_q[i] <= 1'b1;
        if (trig_mode[i] == QAFC_TRG_OFF)
          armed_q[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // priority and forwarding
  // ----------------------------------------
  // lowest ready queue wins; only when triggered
  always_comb begin
    grant_v = 1'b0;
    grant = 3'h0;
    for (int i = 0; i < `QAFC_NQ; i++) begin
      trig_act[i] = armed_q[i] || (trig_mode[i] == QAFC_TRG_HIGH && tflt_q[i]) ||
                    (trig_mode[i] == QAFC_TRG_LOW && !tflt_q[i]);
      elig[i] = trig_act[i] && cq_cnt_q[i] != 3'h0;
    end
    for (int i = `QAFC_NQ - 1; i >= 0; i--) begin
      if (elig[i] && sb_cnt_q != `QAFC_SB_DEPTH) begin
        grant_v = 1'b1;
        grant = 3'(i);
      end
    end
  end

  // coherency lost when a batch is cut by another queue
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_q_q <= 3'h7;
      mid_q <= 1'b0;
      coh_irq <= 6'h00;
    end else begin
      coh_irq <= 6'h00;
      if (grant_v) begin
        if (mid_q && grant != last_q_q)
          coh_irq[last_q_q] <= 1'b1;
        last_q_q <= grant;
        mid_q <= !cq_mem[grant][cq_rp_q[grant]][`QAFC_F_EOQ];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `QAFC_NQ; i++) begin
        cq_wp_q[i] <= 2'h0;
        cq_rp_q[i] <= 2'h0;
        cq_cnt_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < `QAFC_NQ; i++) begin
        logic psh, pop;
        psh = cmd_push.valid && cmd_push.qid == 3'(i) && cq_cnt_q[i] != `QAFC_DEPTH;
        pop = grant_v && grant == 3'(i);
        if (psh) begin
          cq_mem[i][cq_wp_q[i]] <= cmd_push.data;
          cq_wp_q[i] <= cq_wp_q[i] + 2'h1;
        end
        if (pop)
          cq_rp_q[i] <= cq_rp_q[i] + 2'h1;
        cq_cnt_q[i] <= cq_cnt_q[i] + 3'(psh) - 3'(pop);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sb_wp_q <= 1'b0;
      sb_rp_q <= 1'b0;
      sb_cnt_q <= 2'h0;
    end else begin
      if (grant_v) begin
        sb_mem[sb_wp_q] <= cq_mem[grant][cq_rp_q[grant]];
        sb_wp_q <= !sb_wp_q;
      end
      if (sb_pop)
        sb_rp_q <= !sb_rp_q;
      sb_cnt_q <= sb_cnt_q + 2'(grant_v) - 2'(sb_pop);
    end
  end

  // ----------------------------------------
  // converter control
  // ----------------------------------------
  // decode and run one command at a time
  assign sb_pop = st_q == QAFC_IDLE && sb_cnt_q != 2'h0;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= QAFC_IDLE;
      cur_q <= 32'h0000_0000;
      scnt_q <= 8'h00;
      stamp_q <= 16'h0000;
      res_val_q <= 16'h0000;
    end else begin
      unique case (st_q)
        QAFC_IDLE: begin
          if (sb_pop) begin
            cur_q <= sb_mem[sb_rp_q];
            scnt_q <= 8'h01;
            st_q <= QAFC_SAMP;
          end
        end
        QAFC_SAMP: begin
          scnt_q <= scnt_q + 8'h01;
          if (scnt_q == smp_len(cur_q[`QAFC_F_SMP_HI:`QAFC_F_SMP_LO]))
            st_q <= QAFC_CONV;
        end
        QAFC_CONV: begin
          if (adc_done) begin
            // gain and offset applied, clamped to code range
            logic signed [16:0] cv;
            logic [27:0] prod;
            prod = 28'(adc_raw) * 28'(cal_gain);
            cv = 17'(signed'({1'b0, prod[27:`QAFC_GAIN_SH]}) + 17'(signed'(cal_offset)));
            if (cv < 0)
              cv = 17'sh0;
            else if (cv > 17'(`QAFC_CODE_MAX))
              cv = 17'(`QAFC_CODE_MAX);
            // signed form is offset from mid scale
            if (cur_q[`QAFC_F_SGN])
              res_val_q <= 16'(signed'(cv[12:0] - `QAFC_MID));
            else
              res_val_q <= {4'h0, cv[11:0]};
            stamp_q <= cur_q[`QAFC_F_TS] ? ts_q : 16'h0000;
            st_q <= QAFC_STORE;
          end
        end
        // waits while the named result queue is full
        QAFC_STORE: begin
          if (rq_push || rq_qid >= 3'(`QAFC_NQ))
            st_q <= QAFC_IDLE;
        end
      endcase
    end
  end

  // time base
  always_ff @(posedge ref_clk) begin
    if (rst)
      ts_q <= 16'h0000;
    else
      ts_q <= ts_q + 16'h0001;
  end

  // channels past the internal set go through external muxes
  always_comb begin
    logic [6:0] ch;
    logic [6:0] xi;
    ch = cur_q[`QAFC_F_CH_HI:`QAFC_F_CH_LO];
    xi = ch - `QAFC_INT_CH;
    adc_ctl.start = st_q == QAFC_SAMP && scnt_q == 8'h01;
    adc_ctl.sample = st_q == QAFC_SAMP;
    adc_ctl.ref_sel = cur_q[`QAFC_F_REF_HI:`QAFC_F_REF_LO];
    adc_ctl.ext_en = ch >= `QAFC_INT_CH;
    adc_ctl.ext_sel = adc_ctl.ext_en ? {1'b0, xi[1:0]} : 3'h0;
    adc_ctl.chan = adc_ctl.ext_en ? 6'(`QAFC_EXT_BASE + 6'(xi[4:2])) : ch[5:0];
  end

  // ----------------------------------------
  // result queues
  // ----------------------------------------
  // routed by command field; pops run alongside
  assign rq_qid = cur_q[`QAFC_F_RQ_HI:`QAFC_F_RQ_LO];
  assign rq_push = st_q == QAFC_STORE && rq_qid < 3'(`QAFC_NQ) && rq_cnt_q[rq_qid] != `QAFC_DEPTH;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_pop_valid <= 1'b0;
      res_pop_data <= 32'h0000_0000;
      for (int i = 0; i < `QAFC_NQ; i++) begin
        rq_wp_q[i] <= 2'h0;
        rq_rp_q[i] <= 2'h0;
        rq_cnt_q[i] <= 3'h0;
      end
    end else begin
      res_pop_valid <= 1'b0;
      for (int i = 0; i < `QAFC_NQ; i++) begin
        logic psh, pop;
        psh = rq_push && rq_qid == 3'(i);
        pop = res_pop_req && res_pop_qid == 3'(i) && rq_cnt_q[i] != 3'h0;
        if (psh) begin
          rq_mem[i][rq_wp_q[i]] <= {stamp_q, res_val_q};
          rq_wp_q[i] <= rq_wp_q[i] + 2'h1;
        end
        if (pop) begin
          res_pop_data <= rq_mem[i][rq_rp_q[i]];
          res_pop_valid <= 1'b1;
          rq_rp_q[i] <= rq_rp_q[i] + 2'h1;
        end
        rq_cnt_q[i] <= rq_cnt_q[i] + 3'(psh) - 3'(pop);
      end
    end
  end

  // fill state requests to host or dma
  always_comb begin
    for (int i = 0; i < `QAFC_NQ; i++) begin
      cmd_push_ready[i] = cq_cnt_q[i] != `QAFC_DEPTH;
      cmd_fill_req[i] = cq_cnt_q[i] != `QAFC_DEPTH && trig_mode[i] != QAFC_TRG_OFF;
      res_drain_req[i] = rq_cnt_q[i] != 3'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] smp_seen_q; // cycles with sample high
  always_ff @(posedge ref_clk) begin
    if (rst)
      smp_seen_q <= 8'h00;
    else
      smp_seen_q <= adc_ctl.sample ? smp_seen_q + 8'h01 : 8'h00;
  end
  AST_DEPTH: assert property (cq_cnt_q[0] <= `QAFC_DEPTH && rq_cnt_q[5] <= `QAFC_DEPTH)
    else $error("queue over four");
  AST_PRIO: assert property (grant_v |-> (elig & ((6'h01 << grant) - 6'h01)) == 6'h00)
    else $error("lower queue skipped");
  AST_SB: assert property (sb_cnt_q == `QAFC_SB_DEPTH |-> !grant_v)
    else $error("staging overrun");
  AST_TRIG: assert property (grant_v |-> trig_act[grant] && $past(cq_cnt_q[grant]) != 3'h7)
    else $error("untriggered forward");
  AST_SMP: assert property ($fell(adc_ctl.sample) |-> smp_seen_q == smp_len($past(cur_q[27:26])))
    else $error("sample length wrong");
  AST_STORE: assert property (rq_push |=> st_q == QAFC_IDLE)
    else $error("result not retired");
  AST_EMPTY: assert property (res_pop_req && rq_cnt_q[res_pop_qid] == 3'h0 |=> !res_pop_valid)
    else $error("empty pop answered");
  AST_COH: assert property (coh_irq != 6'h00 |-> $past(grant_v) && $past(mid_q))
    else $error("spurious coherency irq");
  AST_FULL: assert property (cq_cnt_q[2] == `QAFC_DEPTH && !(grant_v && grant == 3'h2)
    |=> cq_cnt_q[2] == `QAFC_DEPTH)
    else $error("full queue changed");
  COV_CONV: cover property (st_q == QAFC_CONV ##1 st_q == QAFC_STORE);
  COV_COH: cover property (coh_irq != 6'h00);
  COV_SBFULL: cover property (sb_cnt_q == `QAFC_SB_DEPTH);
endmodule

// File: verif/qafc_adc_model.sv
// behavioural converter answering each start with a result
`timescale 1ns/100ps
module qafc_adc_model (
  input wire logic ref_clk,
  input wire qafc_pkg::qafc_adc_s adc_ctl,
  input wire logic [11:0] raw_in,
  output logic adc_done,
  output logic [11:0] adc_raw,
  output logic [7:0] smp_cnt,
  output qafc_pkg::qafc_adc_s last_ctl
);
  import qafc_pkg::*;
  // ----------------------------------------
  // conversion sequence
  // ----------------------------------------
  logic [7:0] n; // sample cycles seen so far
  initial begin
    adc_done = 1'b0;
    adc_raw = 12'hA5A;
    smp_cnt = 8'h00;
    last_ctl = '0;
  end
  // counts sample width, answers three cycles later; data idles inverted so stale values never pass
  always begin
    @(posedge ref_clk iff adc_ctl.start === 1'b1);
    last_ctl = adc_ctl;
    n = 8'h01;
    forever begin
      @(posedge ref_clk);
      if (adc_ctl.sample !== 1'b1) break;
      n++;
    end
    smp_cnt = n;
    repeat (3) @(posedge ref_clk);
    #1 adc_done = 1'b1;
    adc_raw = raw_in;
    @(posedge ref_clk);
    #1 adc_done = 1'b0;
    adc_raw = ~raw_in;
  end
endmodule

// File: verif/tb.sv
// self-checking bench for the queued converter front end
`timescale 1ns/100ps
module tb;
  import qafc_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  qafc_push_s cmd_push = '0;
  logic [5:0] cmd_push_ready, cmd_fill_req, res_drain_req, coh_irq;
  logic res_pop_req = 1'b0;
  logic [2:0] res_pop_qid = 3'h0;
  logic res_pop_valid;
  logic [31:0] res_pop_data;
  qafc_trig_e trig_mode [6];
  logic [5:0] sw_trig = 6'h00;
  logic [5:0] hw_trig_pin = 6'h00;
  qafc_adc_s adc_ctl, last_ctl;
  logic adc_done;
  logic [11:0] adc_raw, raw_in = 12'h000;
  logic [15:0] cal_gain = 16'h4000; // unity gain
  logic [13:0] cal_offset = 14'h0000;
  logic [7:0] smp_cnt;
  int failures = 0;
  int n_checks = 0;
  initial foreach (trig_mode[i]) trig_mode[i] = QAFC_TRG_OFF;
  always #5 ref_clk = ~ref_clk;
  // filter length 2: a level must hold three clocks before the filter accepts it
  qafc_top u_qafc_top (.ref_clk(ref_clk), .rst(rst), .cmd_push(cmd_push), .cmd_push_ready(cmd_push_ready),
    .res_pop_req(res_pop_req), .res_pop_qid(res_pop_qid), .res_pop_valid(res_pop_valid),
    .res_pop_data(res_pop_data), .trig_mode(trig_mode), .sw_trig(sw_trig), .hw_trig_pin(hw_trig_pin),
    .trig_filt_len(4'h2), .cmd_fill_req(cmd_fill_req), .res_drain_req(res_drain_req), .coh_irq(coh_irq),
    .adc_ctl(adc_ctl), .adc_done(adc_done), .adc_raw(adc_raw), .cal_gain(cal_gain), .cal_offset(cal_offset));
  qafc_adc_model u_qafc_adc_model (.ref_clk(ref_clk), .adc_ctl(adc_ctl), .raw_in(raw_in),
    .adc_done(adc_done), .adc_raw(adc_raw), .smp_cnt(smp_cnt), .last_ctl(last_ctl));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // command word: end of batch set, no stamp, no reference level
  function automatic logic [31:0] mk(input logic [2:0] rq, input logic [1:0] smp, input logic sgn,
                                     input logic [6:0] ch);
    mk = {1'b1, rq, smp, 1'b0, sgn, 2'h0, ch, 15'h0000};
  endfunction
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  // host side filling a command queue
  // valid held high across n words so it is never toggled within one step
  task automatic push_n(input logic [2:0] q, input logic [31:0] d, input int n);
    cmd_push.valid = 1'b1;
    cmd_push.qid = q;
    cmd_push.data = d;
    repeat (n) tick();
    cmd_push.valid = 1'b0;
  endtask
  // host side draining a result queue
  task automatic pop(input logic [2:0] q, input logic v, input logic [31:0] e);
    res_pop_req = 1'b1;
    res_pop_qid = q;
    tick();
    res_pop_req = 1'b0;
    chk({31'h0, res_pop_valid}, {31'h0, v});
    if (v) chk(res_pop_data, e);
    tick();
  endtask
  task automatic wait_res(input logic [2:0] q);
    for (int i = 0; i < 400 && res_drain_req[q] !== 1'b1; i++) tick();
  endtask
  task automatic conv(input logic [2:0] q, input logic [31:0] w, input logic [11:0] raw, input logic [31:0] e);
    raw_in = raw;
    trig_mode[q] = QAFC_TRG_SW;
    push_n(q, w, 1);
    sw_trig[q] = 1'b1;
    tick();
    sw_trig[q] = 1'b0;
    wait_res(w[30:28]);
    pop(w[30:28], 1'b1, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({26'h0, cmd_push_ready}, 32'h3F);
    chk({26'h0, cmd_fill_req | res_drain_req | coh_irq}, 32'h0);
    pop(3'h0, 1'b0, 32'h0);
  endtask
  task automatic t_fill;
    trig_mode[2] = QAFC_TRG_SW;
    tick();
    chk({31'h0, cmd_fill_req[2]}, 32'h1);
    push_n(3'h2, mk(3'h5, 2'h0, 1'b0, 7'h07), 5);
    chk({31'h0, cmd_push_ready[2]}, 32'h0);
    chk({31'h0, cmd_fill_req[2]}, 32'h0);
    repeat (30) tick();
    chk({26'h0, res_drain_req}, 32'h0);
    raw_in = 12'hABC;
    // each word ends its batch, so every word needs its own trigger
    repeat (4) begin
      sw_trig[2] = 1'b1;
      tick();
      sw_trig[2] = 1'b0;
      wait_res(3'h5);
      pop(3'h5, 1'b1, 32'h0000_0ABC);
    end
    repeat (100) tick();
    pop(3'h5, 1'b0, 32'h0);
  endtask
  task automatic t_smp;
    logic [7:0] len [4];
    len = '{8'h02, 8'h08, 8'h40, 8'h80};
    for (int s = 0; s < 4; s++) begin
      conv(3'h0, mk(3'h1, s[1:0], 1'b0, 7'h07), 12'h123, 32'h0000_0123);
      chk({24'h0, smp_cnt}, {24'h0, len[s]});
    end
    chk({18'h0, last_ctl}, {18'h0, 1'b1, 1'b1, 6'h07, 2'h0, 1'b0, 3'h0});
  endtask
  task automatic t_fmt;
    conv(3'h1, mk(3'h3, 2'h0, 1'b1, 7'h03), 12'h805, 32'h0000_0005);
    conv(3'h1, mk(3'h3, 2'h0, 1'b1, 7'h03), 12'h000, 32'h0000_F800);
    cal_gain = 16'h2000;
    cal_offset = 14'h0010;
    conv(3'h1, mk(3'h3, 2'h0, 1'b0, 7'h03), 12'h400, 32'h0000_0210);
    cal_gain = 16'h8000;
    cal_offset = 14'h0000;
    conv(3'h1, mk(3'h3, 2'h0, 1'b0, 7'h03), 12'hC00, 32'h0000_0FFF);
    cal_gain = 16'h4000;
    conv(3'h3, mk(3'h0, 2'h0, 1'b0, 7'h2D), 12'h111, 32'h0000_0111);
    chk({29'h0, last_ctl.ext_en, last_ctl.ext_sel[1:0]}, 32'h5);
    chk({26'h0, last_ctl.chan}, 32'h22);
  endtask
  task automatic t_prio;
    trig_mode[1] = QAFC_TRG_SW;
    trig_mode[3] = QAFC_TRG_SW;
    push_n(3'h3, mk(3'h4, 2'h0, 1'b0, 7'h09), 1);
    push_n(3'h1, mk(3'h0, 2'h0, 1'b0, 7'h0B), 1);
    sw_trig = 6'h0A;
    tick();
    sw_trig = 6'h00;
    for (int i = 0; i < 400 && res_drain_req === 6'h00; i++) tick();
    chk({26'h0, res_drain_req}, 32'h01);
    wait_res(3'h4);
    pop(3'h0, 1'b1, 32'h0000_0111);
    pop(3'h4, 1'b1, 32'h0000_0111);
  endtask
  task automatic t_coh;
    int seen;
    seen = 0;
    conv(3'h4, mk(3'h2, 2'h0, 1'b0, 7'h01) & 32'h7FFF_FFFF, 12'h0AA, 32'h0000_00AA);
    trig_mode[0] = QAFC_TRG_SW;
    push_n(3'h0, mk(3'h2, 2'h0, 1'b0, 7'h02), 1);
    sw_trig[0] = 1'b1;
    tick();
    sw_trig[0] = 1'b0;
    for (int i = 0; i < 50; i++) begin
      if (coh_irq[4] === 1'b1) seen++;
      tick();
    end
    chk(seen, 1);
    wait_res(3'h2);
    pop(3'h2, 1'b1, 32'h0000_00AA);
  endtask
  task automatic t_hw;
    trig_mode[5] = QAFC_TRG_RISE;
    raw_in = 12'h5A5;
    push_n(3'h5, mk(3'h3, 2'h0, 1'b0, 7'h04), 1);
    repeat (30) tick();
    chk({26'h0, res_drain_req}, 32'h0);
    hw_trig_pin[5] = 1'b1;
    repeat (20) tick();
    hw_trig_pin[5] = 1'b0;
    wait_res(3'h3);
    pop(3'h3, 1'b1, 32'h0000_05A5);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_reset();
    t_fill();
    t_smp();
    t_fmt();
    t_prio();
    t_coh();
    t_hw();
    print_verdict();
  end
  // the whole sequence needs under a thousand cycles, so this is ample
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
